// ### hw/pms_power_mode_sequencer.v
`timescale 1ns/1ns
`include "pms_regs.vh"
module pms_power_mode_sequencer (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // Board side
   input wire chipPowerUpPin,
   input wire externalResetInputN,
   output reg deepSleepWakeOutput_q,
   // Mode request from software
   input wire [1:0] modeReq,
   input wire modeReqValid,
   input wire [7:0] clkCtrlWr,
   input wire clkCtrlWrEn,
   // Wake sources
   input wire wakeMac,
   input wire wakeHost,
   input wire wakeRtcTimer,
   input wire wakeExtIrq,
   // Processor gating
   input wire waitForInterruptInstruction,
   input wire cpuIrq,
   // Clock status
   input wire xtalStable,
   input wire pllStable,
   // Power and clock controls
   output reg rtcDomainEn_q,
   output reg rtcClkEn_q,
   output reg mainDomainPwr_q,
   output reg xtalEn_q,
   output reg pllEn_q,
   output reg hsClkRun_q,
   output reg [7:0] blockClkEn_q,
   output reg regClear_q,
   output reg [2:0] state_q
);

   // Power state codes
   localparam [2:0] ST_OFF = `PMS_ST_OFF;
   localparam [2:0] ST_ON = `PMS_ST_ON;
   localparam [2:0] ST_SLEEP = `PMS_ST_SLEEP;
   localparam [2:0] ST_DEEP = `PMS_ST_DEEP;
   localparam [2:0] ST_WAKE = `PMS_ST_WAKE;

   // Mode request codes accepted while on
   localparam [1:0] MODE_SLEEP = `PMS_MODE_SLEEP;
   localparam [1:0] MODE_DEEP = `PMS_MODE_DEEP;

   // Clock control reset value and processor gate mask
   localparam [7:0] CLKEN_RST = `PMS_CLKEN_RST;
   localparam [7:0] CPU_MASK = 8'h01 << `PMS_CPU_BIT;

   // Always-on domain runs in every state but off
   function rtcOn;
      input [2:0] s;
      begin
         rtcOn = (s != ST_OFF);
      end
   endfunction

   // Crystal and PLLs run while waking and while on
   function clkSrcOn;
      input [2:0] s;
      begin
         clkSrcOn = (s == ST_ON) || (s == ST_WAKE);
      end
   endfunction

   // Main domain stays powered except in off and deep-sleep
   function mainOn;
      input [2:0] s;
      begin
         mainOn = (s == ST_ON) || (s == ST_WAKE) || (s == ST_SLEEP);
      end
   endfunction

   // True for any state that a wake source may leave toward wake-up
   function isSleeping;
      input [2:0] s;
      begin
         isSleeping = (s == ST_SLEEP) || (s == ST_DEEP);
      end
   endfunction

   // Internal state and next values
   reg [2:0] state_d;
   reg [7:0] clkCtrl_q;
   reg [7:0] clkCtrl_d;
   reg cpuWait_q;
   reg cpuWait_d;
   reg fromDeep_q;
   reg fromDeep_d;
   wire wakeAny;
   wire sleepReq;
   wire deepReq;
   wire clksStable;
   wire resetWake;

   // Wake sources merged into one event
   assign wakeAny = wakeMac | wakeHost | wakeRtcTimer | wakeExtIrq;

   // Board reset loop also ends deep-sleep
   assign resetWake = !externalResetInputN;

   // Mode requests, only looked at while on
   assign sleepReq = modeReqValid && (modeReq == MODE_SLEEP);
   assign deepReq = modeReqValid && (modeReq == MODE_DEEP);

   // Both clock sources must settle before blocks see a clock
   assign clksStable = xtalStable && pllStable;

   // Next power state
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (chipPowerUpPin) state_d = ST_WAKE;
         end
         ST_ON: begin
            if (sleepReq) state_d = ST_SLEEP;
            else if (deepReq) state_d = ST_DEEP;
         end
         ST_SLEEP: begin
            if (wakeAny) state_d = ST_WAKE;
         end
         ST_DEEP: begin
            if (wakeAny || resetWake) state_d = ST_WAKE;
         end
         ST_WAKE: begin
            if (clksStable) state_d = ST_ON;
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
      // Pin low overrides every other cause
      if (!chipPowerUpPin) state_d = ST_OFF;
   end

   // Clock control register, cleared in off
   always @* begin
      clkCtrl_d = clkCtrl_q;
      if (state_d == ST_OFF) begin
         clkCtrl_d = CLKEN_RST;
      end else if (clkCtrlWrEn) begin
         clkCtrl_d = clkCtrlWr;
      end
   end

   // Remembers that wake-up began in deep-sleep
   always @* begin
      fromDeep_d = fromDeep_q;
      if (state_d == ST_DEEP) begin
         fromDeep_d = 1'b1;
      end else if ((state_d == ST_ON) || (state_d == ST_OFF)) begin
         fromDeep_d = 1'b0;
      end
   end

   // Processor gate; an interrupt in the same cycle wins
   always @* begin
      cpuWait_d = cpuWait_q;
      if ((state_d != ST_ON) || cpuIrq) begin
         cpuWait_d = 1'b0;
      end else if (waitForInterruptInstruction) begin
         cpuWait_d = 1'b1;
      end
   end

   // State register
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // Control register and flags
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         clkCtrl_q <= CLKEN_RST;
         cpuWait_q <= 1'b0;
         fromDeep_q <= 1'b0;
      end else begin
         clkCtrl_q <= clkCtrl_d;
         cpuWait_q <= cpuWait_d;
         fromDeep_q <= fromDeep_d;
      end
   end

   // Always-on domain power and clock
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rtcDomainEn_q <= 1'b0;
         rtcClkEn_q <= 1'b0;
      end else begin
         rtcDomainEn_q <= rtcOn(state_d);
         rtcClkEn_q <= rtcOn(state_d);
      end
   end

   // Main domain power, off in deep-sleep
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mainDomainPwr_q <= 1'b0;
      end else begin
         mainDomainPwr_q <= mainOn(state_d);
      end
   end

   // Crystal and PLL enables, off in both sleep states
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         xtalEn_q <= 1'b0;
         pllEn_q <= 1'b0;
      end else begin
         xtalEn_q <= clkSrcOn(state_d);
         pllEn_q <= clkSrcOn(state_d);
      end
   end

   // High-speed clock and per-block gates
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hsClkRun_q <= 1'b0;
         blockClkEn_q <= 8'h00;
      end else begin
         hsClkRun_q <= (state_d == ST_ON);
         if (state_d == ST_ON) begin
            blockClkEn_q <= clkCtrl_d & ~(cpuWait_q ? CPU_MASK : 8'h00);
         end else begin
            blockClkEn_q <= 8'h00;
         end
      end
   end

   // Register clear and deep-sleep wake level
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         regClear_q <= 1'b1;
         deepSleepWakeOutput_q <= 1'b1;
      end else begin
         regClear_q <= (state_d == ST_OFF);
         // Low toward board reset only while waking from deep-sleep
         deepSleepWakeOutput_q <= !((state_d == ST_WAKE) && fromDeep_d);
      end
   end

   // Unused helper kept for sleep-state decode in wake path
   wire sleepingNow;
   assign sleepingNow = isSleeping(state_q);
endmodule // pms_power_mode_sequencer

// ### include/pms_regs.vh
`ifndef PMS_REGS_VH
`define PMS_REGS_VH
`define PMS_ST_OFF 3'h0
`define PMS_ST_ON 3'h1
`define PMS_ST_SLEEP 3'h2
`define PMS_ST_DEEP 3'h3
`define PMS_ST_WAKE 3'h4
`define PMS_MODE_ACTIVE 2'h0
`define PMS_MODE_SLEEP 2'h1
`define PMS_MODE_DEEP 2'h2
`define PMS_NBLK 8
`define PMS_CPU_BIT 0
`define PMS_CLKEN_RST 8'h00
`endif

// ### sim/pms_partner.sv
`timescale 1ns/1ns
module pms_partner (input wire clk_sys, input wire [4:0] cmd, input wire deepSleepWakeOutput_q,
   output reg [4:0] pins, output wire externalResetInputN);
   // Board loop from wake output to reset
   assign externalResetInputN = deepSleepWakeOutput_q;
   // Pin and wake levels move after falling edge
   always @(negedge clk_sys) pins <= cmd;
endmodule // pms_partner

// ### sim/pms_power_mode_sequencer_assertions.sv
`timescale 1ns/1ns
module pms_chk (input wire clk_sys, input wire rst_n, input wire chipPowerUpPin,
   input wire wakeMac, input wire wakeHost, input wire wakeRtcTimer, input wire wakeExtIrq,
   input wire xtalStable, input wire pllStable, input wire rtcDomainEn_q, input wire rtcClkEn_q,
   input wire mainDomainPwr_q, input wire xtalEn_q, input wire pllEn_q, input wire hsClkRun_q,
   input wire [7:0] blockClkEn_q, input wire regClear_q, input wire [2:0] state_q);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_off; !chipPowerUpPin |=> state_q == 3'h0 && regClear_q && !rtcDomainEn_q; endproperty
   a_off: assert property (p_off) else $error("off");
   property p_dp; state_q == 3'h3 |-> rtcDomainEn_q && !mainDomainPwr_q; endproperty
   a_dp: assert property (p_dp) else $error("deep");
   property p_rc; state_q == 3'h3 |-> rtcClkEn_q; endproperty
   a_rc: assert property (p_rc) else $error("rtc");
   property p_sl; state_q == 3'h2 |-> !xtalEn_q && rtcClkEn_q; endproperty
   a_sl: assert property (p_sl) else $error("sleep");
   property p_wu; state_q[1] && chipPowerUpPin && (wakeMac | wakeHost | wakeRtcTimer | wakeExtIrq)
      |=> state_q == 3'h4; endproperty
   a_wu: assert property (p_wu) else $error("wake");
   property p_wk; state_q == 3'h4 |-> xtalEn_q && pllEn_q; endproperty
   a_wk: assert property (p_wk) else $error("xtal");
   property p_on; state_q != 3'h1 |-> !hsClkRun_q && blockClkEn_q == 8'h00; endproperty
   a_on: assert property (p_on) else $error("gate");
   property p_st; state_q == 3'h4 && chipPowerUpPin && !(xtalStable && pllStable)
      |=> state_q == 3'h4; endproperty
   a_st: assert property (p_st) else $error("stable");
   c_sl: cover property (state_q == 3'h2 ##1 state_q == 3'h4);
   c_dp: cover property (state_q == 3'h3 ##1 state_q == 3'h4);
   c_off: cover property (state_q == 3'h1 ##1 state_q == 3'h0);
endmodule // pms_chk
bind pms_power_mode_sequencer pms_chk chk_i (.clk_sys, .rst_n, .chipPowerUpPin, .wakeMac,
   .wakeHost, .wakeRtcTimer, .wakeExtIrq, .xtalStable, .pllStable, .rtcDomainEn_q, .rtcClkEn_q,
   .mainDomainPwr_q, .xtalEn_q, .pllEn_q, .hsClkRun_q, .blockClkEn_q, .regClear_q, .state_q);

// ### sim/tb_power_mode_sequencer.sv
`timescale 1ns/1ns
module tb_power_mode_sequencer;
   reg clk_sys = 0, rst_n = 0, stab = 0, mv = 0;
   reg [4:0] cmd = 0;
   reg [1:0] mr = 0;
   reg wfi = 0, irq = 0, cwe = 1;
   reg [7:0] cw = 8'h5b;
   wire [4:0] pins;
   wire [7:0] bce;
   wire [2:0] st;
   wire xo, xr;
   int mismatches = 0, checks_done = 0, cyc = 0;
   pms_partner bp (.clk_sys(clk_sys), .cmd(cmd), .deepSleepWakeOutput_q(xo), .pins(pins),
      .externalResetInputN(xr));
   pms_power_mode_sequencer uut (.clk_sys(clk_sys), .rst_n(rst_n), .chipPowerUpPin(pins[0]),
      .externalResetInputN(xr), .deepSleepWakeOutput_q(xo), .modeReq(mr), .modeReqValid(mv),
      .clkCtrlWr(cw), .clkCtrlWrEn(cwe), .wakeMac(pins[1]), .wakeHost(pins[2]),
      .wakeRtcTimer(pins[3]), .wakeExtIrq(pins[4]), .waitForInterruptInstruction(wfi),
      .cpuIrq(irq), .xtalStable(stab), .pllStable(stab), .rtcDomainEn_q(), .rtcClkEn_q(),
      .mainDomainPwr_q(), .xtalEn_q(), .pllEn_q(), .hsClkRun_q(), .blockClkEn_q(bce),
      .regClear_q(), .state_q(st));
   task chk(input [7:0] g, input [7:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task step(input [4:0] c, input m);
      cmd <= c;
      mv <= m;
      repeat (2) @(negedge clk_sys);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Clock and hang limit
   initial forever #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc > 2000) begin
      mismatches++;
      print_verdict;
   end
   // Pin high wakes, stable clocks reach on
   task scn_power_up;
      step(5'h01, 0);
      chk(st, 8'h04);
      step(5'h01, 0);
      chk(st, 8'h04);
      stab = 1;
      step(5'h01, 0);
      chk(st, 8'h01);
      chk(bce, 8'h5b);
   endtask
   // Wait instruction gates bit 0, interrupt ungates, held control
   task scn_cpu_gate;
      wfi <= 1;
      step(5'h01, 0);
      wfi <= 0;
      chk(bce, 8'h5a);
      irq <= 1;
      step(5'h01, 0);
      irq <= 0;
      chk(bce, 8'h5b);
      cwe <= 0;
      cw <= 8'h00;
      step(5'h01, 0);
      chk(bce, 8'h5b);
      cwe <= 1;
      cw <= 8'h5b;
   endtask
   // Sleep and wake once per source
   task scn_sleep_wake;
      for (int i = 1; i < 5; i++) begin
         mr = 1;
         step(5'h01, 1);
         chk(st, 8'h02);
         step(5'h01 | (5'h01 << i), 0);
         chk(st, 8'h04);
         chk(xo, 8'h01);
         step(5'h01, 0);
         chk(st, 8'h01);
      end
   endtask
   // Deep-sleep entry, hold and wake
   task scn_deep;
      mr = 2;
      step(5'h01, 1);
      chk(st, 8'h03);
      step(5'h01, 0);
      chk(st, 8'h03);
      step(5'h05, 0);
      chk(st, 8'h04);
      chk(xo, 8'h00);
   endtask
   // Pin low forces off and closes all gates
   task scn_off;
      step(5'h00, 0);
      chk(st, 8'h00);
      chk(bce, 8'h00);
   endtask
   // Scenario sequence
   initial begin
      repeat (3) @(negedge clk_sys);
      rst_n = 1;
      scn_power_up;
      scn_cpu_gate;
      scn_sleep_wake;
      scn_deep;
      scn_off;
      print_verdict;
   end
endmodule // tb_power_mode_sequencer
